// File: core/fpm_pkg.sv
package fpm_pkg;

    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam int          CODE_AW       = 12;
    localparam logic [15:0] SEC_ADDR      = 16'hffff;
    localparam logic [7:0]  ERASE_DATA    = 8'hff;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam int          SEC_LOCK_BIT  = 0;
    localparam int          SEC_TBL_BIT   = 1;
    localparam int          SEC_ENC_BIT   = 2;
    localparam logic [7:0]  SEC_RESET     = 8'hff;
    localparam logic [7:0]  ENC_KEY       = 8'h5a;

    // Supply level of the program-voltage pin, as seen by a level detector
    typedef enum logic [1:0] {
        FPM_VPP_LOGIC = 2'b00,
        FPM_VPP_PROG  = 2'b01,
        FPM_VPP_ERASE = 2'b10,
        FPM_VPP_LOW   = 2'b11
    } fpm_vpp_e;

    typedef enum logic [2:0] {
        FPM_OP_NONE    = 3'b000,
        FPM_OP_READ    = 3'b001,
        FPM_OP_PROG    = 3'b010,
        FPM_OP_PVERIFY = 3'b011,
        FPM_OP_ERASE   = 3'b100,
        FPM_OP_EVERIFY = 3'b101,
        FPM_OP_ID      = 3'b110
    } fpm_op_e;

endpackage

// File: core/fpm_sync.sv
`timescale 1ns/1ps
module fpm_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk, // Clock
    input  wire logic         srst,     // Sync reset
    input  wire logic [W-1:0] d,        // Async input
    output logic      [W-1:0] q         // Synchronised output
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fpm_sync_s;

    fpm_sync_s st_r;
    fpm_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule

// File: core/fpm_decode.sv
`timescale 1ns/1ps
module fpm_decode (
    input  wire logic            rst_pin,              // Reset pin level
    input  wire logic            ale,                  // Addr latch strobe
    input  wire logic            program_store_strobe_n, // Store strobe
    input  wire logic            id_erase_select,      // Id/erase select
    input  wire logic            upper_addr_control_a, // Aux control a
    input  wire logic            upper_addr_control_b, // Aux control b
    input  wire logic            aux_output_control,   // Aux control c
    input  wire logic            ce_n,                 // Chip select
    input  wire logic            oe_n,                 // Output strobe
    input  wire fpm_pkg::fpm_vpp_e vpp,                // Vpp level
    input  wire logic            addr0,                // Address bit 0
    input  wire logic [7:0]      din,                  // Data port in
    output fpm_pkg::fpm_op_e     op                    // Decoded op
);
    logic mode_ok;
    logic aux_low;

    assign mode_ok = rst_pin && !ale && program_store_strobe_n;
    assign aux_low = !upper_addr_control_a && !upper_addr_control_b
                     && !aux_output_control;

    always_comb begin
        op = fpm_pkg::FPM_OP_NONE;
        if (mode_ok && aux_low) begin
            case ({id_erase_select, ce_n, oe_n})
                3'b000: begin
                    if (vpp == fpm_pkg::FPM_VPP_LOGIC) begin
                        op = fpm_pkg::FPM_OP_READ;
                    end
                end
                3'b001: begin
                    if (vpp == fpm_pkg::FPM_VPP_PROG) begin
                        op = fpm_pkg::FPM_OP_PROG;
                    end
                end
                3'b010: begin
                    if (vpp == fpm_pkg::FPM_VPP_PROG) begin
                        op = fpm_pkg::FPM_OP_PVERIFY;
                    end
                end
                3'b100: begin
                    if (vpp == fpm_pkg::FPM_VPP_LOGIC) begin
                        op = fpm_pkg::FPM_OP_ID;
                    end
                end
                3'b101: begin
                    if (vpp == fpm_pkg::FPM_VPP_ERASE && !addr0
                        && din == fpm_pkg::ERASE_DATA) begin
                        op = fpm_pkg::FPM_OP_ERASE;
                    end
                end
                3'b110: begin
                    if (vpp == fpm_pkg::FPM_VPP_ERASE) begin
                        op = fpm_pkg::FPM_OP_EVERIFY;
                    end
                end
                // Both selects high: inhibit, nothing happens
                default: op = fpm_pkg::FPM_OP_NONE;
            endcase
        end
    end
endmodule

// File: core/fpm_flash_prog.sv
`timescale 1ns/1ps
// What this block does
// - Operations only with reset high, strobes set
// - Ports 2/1 carry address, port 0 data
// - Read drives code byte or security bits
// - Locked device returns no valid code
// - Output strobe high floats data port
// - Program byte at program voltage, select low
// - Program verify outputs addressed byte
// - Chip erase sets everything to ones
// - Erase verify outputs addressed byte
// - Both selects high inhibits program/erase
// - Id read, address bit 0 picks code
// - Security and id only in programming mode
// - Security bits only return to one by erase or srst
// - Top address selects security register
// - Lock zero refuses array and setting access
// - Restricted table read from external: external only
// - Internal table reads unrestricted; bit one frees all
// - Encryption bit encodes port-0 data
// - Identification codes are fixed, read-only
module fpm_flash_prog #(
    parameter int          CODE_AW    = fpm_pkg::CODE_AW,
    parameter logic [7:0]  MAKER_CODE = 8'h11, // Arbitrary value
    parameter logic [7:0]  PART_CODE  = 8'h22  // Arbitrary value
) (
    input  wire logic            core_clk,               // 200 MHz clock
    input  wire logic            srst,                   // Sync reset
    input  wire logic            rst_pin,                // Reset pin
    input  wire logic            ale,                    // Addr latch strobe
    input  wire logic            program_store_strobe_n, // Store strobe
    input  wire logic            id_erase_select,        // Id/erase select
    input  wire logic            upper_addr_control_a,   // Aux control a
    input  wire logic            upper_addr_control_b,   // Aux control b
    input  wire logic            aux_output_control,     // Aux control c
    input  wire logic            ce_n,                   // Chip select
    input  wire logic            oe_n,                   // Output strobe
    input  wire logic [1:0]      vpp_level,              // Vpp detector
    input  wire logic [7:0]      p2_in,                  // Address high
    input  wire logic [7:0]      p1_in,                  // Address low
    input  wire logic [7:0]      p0_in,                  // Data port in
    output logic      [7:0]      p0_out,                 // Data port out
    output logic                 p0_oe,                  // Data port drive
    input  wire logic            tbl_rd_req,             // Table read request
    input  wire logic            tbl_from_internal,      // Code runs inside
    input  wire logic [15:0]     tbl_addr,               // Table read address
    output logic                 tbl_use_internal,       // Internal reachable
    output logic [7:0]           tbl_data,               // Internal code byte
    input  wire logic [7:0]      bus_data_raw,           // Port 0 data, plain
    output logic [7:0]           bus_data_enc,           // Port 0 data, coded
    output logic                 lock_active,            // Lock bit zero
    output logic                 busy                    // Program or erase in progress
);
    localparam int DEPTH = 1 << CODE_AW;

    // Control pins are asynchronous to core_clk
    localparam int SW = 10 + 2 + 24;

    typedef struct packed {
        logic [7:0]  sec;
        logic [7:0]  dout;
        logic        dout_en;
        logic        prog_done;
        logic        erase_done;
    } fpm_state_s;

    fpm_state_s        st_r;
    fpm_state_s        st_nxt;
    logic [7:0]        mem_r [DEPTH];
    logic [SW-1:0]     raw;
    logic [SW-1:0]     syn;
    logic [15:0]       addr;
    logic [7:0]        din;
    fpm_pkg::fpm_op_e  op;
    fpm_pkg::fpm_vpp_e vpp;
    logic              in_array;
    logic              is_sec;
    logic              locked;
    logic              do_prog;
    logic              do_erase;
    logic [CODE_AW-1:0] idx;

    function automatic logic [7:0] encode(input logic [7:0] b,
                                          input logic en);
        encode = en ? (b ^ fpm_pkg::ENC_KEY) : b;
    endfunction

    assign raw = {rst_pin, ale, program_store_strobe_n, id_erase_select,
                  upper_addr_control_a, upper_addr_control_b,
                  aux_output_control, ce_n, oe_n, 1'b0, vpp_level,
                  p2_in, p1_in, p0_in};

    fpm_sync #(
        .W (SW)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .d        (raw),
        .q        (syn)
    );

    assign addr = syn[23:8];
    assign din  = syn[7:0];
    assign vpp  = fpm_pkg::fpm_vpp_e'(syn[25:24]);

    fpm_decode u_dec (
        .rst_pin                (syn[35]),
        .ale                    (syn[34]),
        .program_store_strobe_n (syn[33]),
        .id_erase_select        (syn[32]),
        .upper_addr_control_a   (syn[31]),
        .upper_addr_control_b   (syn[30]),
        .aux_output_control     (syn[29]),
        .ce_n                   (syn[28]),
        .oe_n                   (syn[27]),
        .vpp                    (vpp),
        .addr0                  (addr[0]),
        .din                    (din),
        .op                     (op)
    );

    assign idx      = addr[CODE_AW-1:0];
    assign in_array = (addr < 16'(DEPTH));
    assign is_sec   = (addr == fpm_pkg::SEC_ADDR);
    assign locked   = !st_r.sec[fpm_pkg::SEC_LOCK_BIT];

    // Program is edge-free: a held op writes the same byte each cycle,
    // which is harmless since bits only clear.
    assign do_prog  = (op == fpm_pkg::FPM_OP_PROG) && !locked;
    assign do_erase = (op == fpm_pkg::FPM_OP_ERASE);

    always_comb begin
        st_nxt         = st_r;
        st_nxt.dout    = '0;
        st_nxt.dout_en = 1'b0;
        st_nxt.prog_done  = do_prog;
        st_nxt.erase_done = do_erase;
        case (op)
            fpm_pkg::FPM_OP_READ,
            fpm_pkg::FPM_OP_PVERIFY,
            fpm_pkg::FPM_OP_EVERIFY: begin
                st_nxt.dout_en = 1'b1;
                if (locked) begin
                    st_nxt.dout = '0;
                end else if (is_sec) begin
                    st_nxt.dout = st_r.sec;
                end else if (in_array) begin
                    st_nxt.dout = mem_r[idx];
                end else begin
                    st_nxt.dout = fpm_pkg::ERASED_BYTE;
                end
            end
            fpm_pkg::FPM_OP_ID: begin
                st_nxt.dout_en = 1'b1;
                if (locked) begin
                    st_nxt.dout = '0;
                end else begin
                    st_nxt.dout = addr[0] ? PART_CODE : MAKER_CODE;
                end
            end
            fpm_pkg::FPM_OP_PROG: begin
                if (do_prog && is_sec) begin
                    st_nxt.sec = st_r.sec & din;
                end
            end
            fpm_pkg::FPM_OP_ERASE: begin
                st_nxt.sec = fpm_pkg::SEC_RESET;
            end
            default: begin
                st_nxt.dout_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '{sec: fpm_pkg::SEC_RESET, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Array kept outside the struct: too large to copy every cycle
    always_ff @(posedge core_clk) begin
        if (do_erase) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= fpm_pkg::ERASED_BYTE;
            end
        end else if (do_prog && in_array) begin
            mem_r[idx] <= mem_r[idx] & din;
        end
    end

    // Output strobe high gates the driver at once, not after sync
    assign p0_oe  = st_r.dout_en && !oe_n;
    assign p0_out = st_r.dout;

    // Security and id stay unreachable here: only array data goes out
    always_comb begin
        tbl_use_internal = 1'b0;
        tbl_data         = '0;
        if (tbl_rd_req && tbl_addr < 16'(DEPTH)) begin
            if (tbl_from_internal
                || st_r.sec[fpm_pkg::SEC_TBL_BIT]) begin
                tbl_use_internal = 1'b1;
            end else begin
                tbl_use_internal = 1'b0;
            end
        end
        if (tbl_use_internal) begin
            tbl_data = mem_r[tbl_addr[CODE_AW-1:0]];
        end
    end

    assign bus_data_enc = encode(bus_data_raw,
                                 !st_r.sec[fpm_pkg::SEC_ENC_BIT]);
    assign lock_active  = locked;
    assign busy         = st_r.prog_done || st_r.erase_done;
endmodule

// File: tb/fpm_flash_prog_chk.sv
`timescale 1ns/1ps
module fpm_flash_prog_chk #(
    parameter int         CODE_AW    = fpm_pkg::CODE_AW,
    parameter logic [7:0] MAKER_CODE = 8'h11 // Arbitrary value
) (
    input wire logic       core_clk,               // Clock
    input wire logic       srst,                   // Sync reset
    input wire logic       rst_pin,                // Reset pin
    input wire logic       ale,                    // Latch strobe
    input wire logic       program_store_strobe_n, // Store strobe
    input wire logic       id_erase_select,        // Id/erase select
    input wire logic       upper_addr_control_a,   // Aux a
    input wire logic       upper_addr_control_b,   // Aux b
    input wire logic       aux_output_control,     // Aux c
    input wire logic       ce_n,                   // Chip select
    input wire logic       oe_n,                   // Output strobe
    input wire logic [1:0] vpp_level,              // Vpp level
    input wire logic [7:0] p1_in,                  // Address low
    input wire logic [7:0] p0_out,                 // Data out
    input wire logic       p0_oe,                  // Data drive
    input wire logic       tbl_rd_req,             // Table read
    input wire logic       tbl_from_internal,      // Runs inside
    input wire logic [15:0] tbl_addr,              // Table address
    input wire logic       tbl_use_internal,       // Inside reachable
    input wire logic       lock_active             // Locked
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    logic mode_c, out_c, id_c, er_c, pg_c;
    assign mode_c = rst_pin && !ale && program_store_strobe_n
        && !upper_addr_control_a && !upper_addr_control_b
        && !aux_output_control;
    // Verify needs the voltage that matches the select line
    assign out_c = mode_c && !oe_n && (ce_n ?
        vpp_level == {id_erase_select, !id_erase_select} : vpp_level == 2'b00);
    assign id_c = out_c && !ce_n && id_erase_select && !lock_active
        && !p1_in[0];
    assign er_c = mode_c && id_erase_select && !ce_n && oe_n
        && vpp_level == 2'b10 && !p1_in[0];
    assign pg_c = mode_c && !ce_n && oe_n && vpp_level == 2'b01;
    AST_OE_FLOAT: assert property (oe_n |-> !p0_oe)
        else $error("port 0 driven with output strobe high");
    AST_DRIVE_CAUSE: assert property (p0_oe |-> $past(out_c, 3))
        else $error("port 0 driven without a read operation");
    AST_OUT_DRIVE: assert property (out_c [*4] |-> p0_oe)
        else $error("read operation left port 0 floating");
    AST_LOCK_ZERO: assert property (lock_active && p0_oe |-> p0_out == 8'h00)
        else $error("locked device returned data");
    AST_ID_CODE: assert property (id_c [*4] |-> p0_out == MAKER_CODE)
        else $error("maker code wrong");
    AST_LOCK_KEEP: assert property ($fell(lock_active) |-> $past(er_c, 3))
        else $error("lock cleared without erase");
    AST_LOCK_SET: assert property ($rose(lock_active) |-> $past(pg_c, 3))
        else $error("lock set without program");
    // Internal reads of addresses inside the code array must always be served internally
    AST_TBL_INT: assert property (tbl_rd_req && tbl_from_internal
        && (tbl_addr >> CODE_AW) == 16'h0000 |-> tbl_use_internal)
        else $error("internal table read refused");
    COV_READ: cover property (out_c [*4]);
    COV_UNLOCK: cover property ($fell(lock_active));
    COV_TBL: cover property (tbl_rd_req && !tbl_use_internal);
endmodule
bind fpm_flash_prog fpm_flash_prog_chk #(.CODE_AW(CODE_AW),
    .MAKER_CODE(MAKER_CODE)) u_chk (
    .core_clk(core_clk), .srst(srst), .rst_pin(rst_pin), .ale(ale),
    .program_store_strobe_n(program_store_strobe_n),
    .id_erase_select(id_erase_select), .ce_n(ce_n), .oe_n(oe_n),
    .upper_addr_control_a(upper_addr_control_a),
    .upper_addr_control_b(upper_addr_control_b),
    .aux_output_control(aux_output_control), .vpp_level(vpp_level),
    .p1_in(p1_in), .p0_out(p0_out), .p0_oe(p0_oe), .tbl_rd_req(tbl_rd_req),
    .tbl_from_internal(tbl_from_internal), .tbl_addr(tbl_addr),
    .tbl_use_internal(tbl_use_internal), .lock_active(lock_active));

// File: tb/fpm_prog_model.sv
`timescale 1ns/1ps
module fpm_prog_model (
    input  wire logic       core_clk, // Clock
    input  wire logic       dev_oe,   // Device drives
    input  wire logic [7:0] dev_d,    // Device data
    input  wire logic       prg_oe,   // Programmer drives
    input  wire logic [7:0] prg_d,    // Programmer data
    output logic      [7:0] p0_wire   // Resolved port 0
);
    logic [7:0] last_r;
    // Floating bus shows inverse of last value, so stale data never matches
    always_comb begin
        if (dev_oe)
            p0_wire = dev_d;
        else if (prg_oe)
            p0_wire = prg_d;
        else
            p0_wire = ~last_r;
    end
    // Plain always: the initial value below writes last_r as well
    always @(posedge core_clk) begin
        if (dev_oe || prg_oe)
            last_r <= p0_wire;
    end
    initial last_r = 8'h00;
endmodule

// File: tb/fpm_flash_prog_tb_top.sv
`timescale 1ns/1ps
module fpm_flash_prog_tb_top;
    localparam logic [1:0] VL = fpm_pkg::FPM_VPP_LOGIC;
    localparam logic [1:0] VP = fpm_pkg::FPM_VPP_PROG;
    localparam logic [1:0] VE = fpm_pkg::FPM_VPP_ERASE;
    localparam logic [7:0] MAKER_ID = 8'h11; // Arbitrary value
    localparam logic [7:0] PART_ID  = 8'h22; // Arbitrary value
    logic core_clk, srst, rst_pin, ale, pss_n, id_sel, ua, ub, aux, ce_n, oe_n;
    logic [1:0] vpp_level;
    logic [7:0] p2_in, p1_in, p0_in, p0_out, prg_d, raw, enc, tbl_data;
    logic p0_oe, prg_oe, tbl_req, tbl_int, use_int, lock_active, busy;
    logic [15:0] tbl_addr;
    int mismatches, comparisons;
    fpm_flash_prog #(.MAKER_CODE(MAKER_ID), .PART_CODE(PART_ID)) dut (
        .core_clk(core_clk), .srst(srst), .rst_pin(rst_pin),
        .ale(ale), .program_store_strobe_n(pss_n), .id_erase_select(id_sel),
        .upper_addr_control_a(ua), .upper_addr_control_b(ub),
        .aux_output_control(aux), .ce_n(ce_n), .oe_n(oe_n),
        .vpp_level(vpp_level), .p2_in(p2_in), .p1_in(p1_in), .p0_in(p0_in),
        .p0_out(p0_out), .p0_oe(p0_oe), .tbl_rd_req(tbl_req),
        .tbl_from_internal(tbl_int), .tbl_addr(tbl_addr),
        .tbl_use_internal(use_int), .tbl_data(tbl_data),
        .bus_data_raw(raw), .bus_data_enc(enc), .lock_active(lock_active),
        .busy(busy));
    fpm_prog_model u_prg (.core_clk(core_clk), .dev_oe(p0_oe),
        .dev_d(p0_out), .prg_oe(prg_oe), .prg_d(prg_d), .p0_wire(p0_in));
    always #2.5 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Programmer drives port 0 only while the device is told to float
    task automatic drive(input logic [2:0] c, input int id, input int ce,
        input int oe, input logic [1:0] v, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge core_clk);
        {ua, ub, aux} <= c;
        {id_sel, ce_n, oe_n, prg_oe} <= {id[0], ce[0], oe[0], oe[0]};
        vpp_level <= v;
        {p2_in, p1_in} <= a;
        prg_d <= d;
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input int id, input int ce, input logic [1:0] v,
        input logic [15:0] a, input logic [7:0] exp);
        drive(3'h0, id, ce, 0, v, a, 8'h00);
        chk(p0_in, exp);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {core_clk, srst, rst_pin, ale, pss_n} = 5'b11101;
        {id_sel, ua, ub, aux, ce_n, oe_n, prg_oe} = 7'b0000110;
        {vpp_level, p2_in, p1_in, prg_d, raw} = '0;
        {tbl_req, tbl_int, tbl_addr} = '0;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        drive(3'h0, 1, 0, 1, VE, 16'h0000, 8'hff);
        rd(1, 1, VE, 16'h0123, 8'hff);
        rd(1, 1, VE, 16'hffff, 8'hff);
        drive(3'h0, 0, 0, 1, VP, 16'h0123, 8'h3c);
        chk({7'h00, busy}, 8'h01);
        rd(0, 1, VP, 16'h0123, 8'h3c);
        chk({7'h00, busy}, 8'h00);
        rd(0, 0, VL, 16'h0023, 8'hff);
        drive(3'h0, 0, 0, 1, VP, 16'h0123, 8'hf0);
        rd(0, 0, VL, 16'h0123, 8'h30);
        drive(3'h0, 0, 1, 1, VP, 16'h0123, 8'h00);
        chk({7'h00, busy}, 8'h00);
        drive(3'h1, 0, 0, 1, VP, 16'h0123, 8'h00);
        rd(0, 0, VL, 16'h0123, 8'h30);
        drive(3'h0, 0, 1, 0, VL, 16'h0123, 8'h00);
        chk({7'h00, p0_oe}, 8'h00);
        drive(3'h0, 0, 0, 1, VL, 16'h0123, 8'h00);
        chk({7'h00, p0_oe}, 8'h00);
        rd(1, 0, VL, 16'h0000, MAKER_ID);
        rd(1, 0, VL, 16'h0001, PART_ID);
        rd(0, 0, VL, 16'hffff, 8'hff);
        drive(3'h0, 0, 0, 1, VP, 16'hffff, 8'hfb);
        @(posedge core_clk);
        {raw, tbl_req, tbl_int, tbl_addr} <= {8'h96, 2'b10, 16'h0123};
        @(posedge core_clk);
        #1;
        chk(enc, 8'h96 ^ fpm_pkg::ENC_KEY);
        chk({7'h00, use_int}, 8'h01);
        drive(3'h0, 0, 0, 1, VP, 16'hffff, 8'hfd);
        chk({7'h00, use_int}, 8'h00);
        @(posedge core_clk);
        tbl_int <= 1'b1;
        @(posedge core_clk);
        #1;
        chk({7'h00, use_int}, 8'h01);
        chk(tbl_data, 8'h30);
        drive(3'h0, 0, 0, 1, VP, 16'hffff, 8'hff);
        rd(0, 0, VL, 16'hffff, 8'hf9);
        @(posedge core_clk);
        rst_pin <= 1'b0;
        drive(3'h0, 0, 0, 0, VL, 16'hffff, 8'h00);
        chk({7'h00, p0_oe}, 8'h00);
        @(posedge core_clk);
        rst_pin <= 1'b1;
        drive(3'h0, 0, 0, 1, VP, 16'hffff, 8'hfe);
        chk({7'h00, lock_active}, 8'h01);
        rd(0, 0, VL, 16'h0123, 8'h00);
        rd(0, 0, VL, 16'hffff, 8'h00);
        drive(3'h0, 0, 0, 1, VP, 16'h0123, 8'h00);
        chk({7'h00, busy}, 8'h00);
        drive(3'h0, 1, 0, 1, VE, 16'h0000, 8'hff);
        chk({7'h00, busy}, 8'h01);
        chk({7'h00, lock_active}, 8'h00);
        rd(1, 1, VE, 16'h0123, 8'hff);
        chk(enc, 8'h96);
        // Whole-array read back after erase, as a programmer must
        for (int i = 0; i < (1 << fpm_pkg::CODE_AW); i++) begin
            rd(1, 1, VE, 16'(i), 8'hff);
        end
        complete_run();
    end
endmodule
